// ==== rtl/core_clock_reset_gating.sv ====
// clock, reset domain and dynamic clock gating control of the core
//
// Functional notes
// - bus outputs change only on enabled edges or in core reset
// - three active-low resets: core, SIMD, debug
// - core reset clears core and FP state
// - SIMD reset clears SIMD engine alone
// - debug reset clears watchpoint values
// - warm reset keeps debug state
// - gating enable and latency in control register
// - integer core clock cut on four stalls
// - system control clock cut when unused
// - SIMD clock cut with no SIMD work
`timescale 1ns/1ps
module core_clock_reset_gating
(
    // clock and bus reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [core_clk_rst_pkg::ADDR_W-1:0] paddr,
    input wire logic [core_clk_rst_pkg::DATA_W-1:0] pwdata,
    output logic [core_clk_rst_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // reset controller
    input wire logic core_reset_n,
    input wire logic simd_reset_n,
    input wire logic debug_reset_n,
    input wire logic simd_clock_off,
    // bus ratio
    input wire logic bus_master_port_bus_clock_enable,
    input wire logic [core_clk_rst_pkg::DATA_W-1:0] core_bus_data,
    input wire logic core_bus_valid,
    output logic [core_clk_rst_pkg::DATA_W-1:0] bus_out_data,
    output logic bus_out_valid,
    // integer core activity
    input wire logic core_empty,
    input wire logic core_full,
    input wire logic icache_linefill_miss,
    input wire logic itlb_miss,
    input wire logic dcache_linefill_miss,
    input wire logic store_stall_lfb_busy,
    // system control activity
    input wire logic sysctl_instr_exec,
    input wire logic sysctl_instr_pipe,
    input wire logic perf_events_en,
    input wire logic debug_en,
    // simd engine activity
    input wire logic simd_instr_engine,
    input wire logic simd_instr_pipe,
    // clock enables and reset state
    output logic core_clk_en,
    output logic sysctl_clk_en,
    output logic simd_clk_en,
    output logic core_in_reset,
    output logic simd_in_reset,
    output logic debug_in_reset,
    output logic [2:0] reset_mode
);
    import core_clk_rst_pkg::*;
    // ---------------- apb access decode
    logic setup_ph, access_ph, wr_ok;
    logic [DATA_W-1:0] rdata_q, rdata_d;

    // ---------------- register state
    logic [DATA_W-1:0] pwr_ctrl_q, pwr_ctrl_d;
    logic [DATA_W-1:0] watch_q, watch_d;
    logic [DATA_W-1:0] simd_state_q, simd_state_d;
    logic [DATA_W-1:0] fp_state_q, fp_state_d;

    // ---------------- reset status
    reset_mode_t mode_q, mode_d;
    logic [2:0] in_rst_q, in_rst_d;

    // ---------------- gating
    logic gate_en;
    logic [LAT_W-1:0] max_lat;
    logic [NUM_GATED-1:0] idle_vec, hold_vec, off_vec, en_vec;
    logic [DATA_W-1:0] status_word;

    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign wr_ok = access_ph && pwrite && is_mapped(paddr);
    // zero-wait access phase; read data is captured during setup
    assign pready = 1'b1;
    assign pslverr = access_ph && !is_mapped(paddr);

    assign gate_en = pwr_ctrl_q[GATE_EN_BIT];
    assign max_lat = pwr_ctrl_q[LAT_LSB +: LAT_W];

    always_comb begin
        status_word = '0;
        status_word[STAT_MODE_LSB +: 3] = mode_q;
        status_word[STAT_CLK_LSB +: NUM_GATED] = en_vec;
        status_word[STAT_RST_LSB +: 3] = in_rst_q;
    end

    always_comb begin
        rdata_d = rdata_q;
        if (setup_ph) begin
            case (paddr)
                PWR_CTRL_OFF: rdata_d = pwr_ctrl_q;
                STATUS_OFF: rdata_d = status_word;
                WATCH_OFF: rdata_d = watch_q;
                SIMD_STATE_OFF: rdata_d = simd_state_q;
                FP_STATE_OFF: rdata_d = fp_state_q;
                default: rdata_d = '0;
            endcase
        end
    end

    // each register is cleared by its own reset domain only; reset beats a write
    always_comb begin
        pwr_ctrl_d = pwr_ctrl_q;
        watch_d = watch_q;
        simd_state_d = simd_state_q;
        fp_state_d = fp_state_q;
        if (wr_ok && paddr == PWR_CTRL_OFF) begin
            pwr_ctrl_d = pwdata & PWR_CTRL_MASK;
        end
        if (wr_ok && paddr == WATCH_OFF) begin
            watch_d = pwdata;
        end
        if (wr_ok && paddr == SIMD_STATE_OFF) begin
            simd_state_d = pwdata;
        end
        if (wr_ok && paddr == FP_STATE_OFF) begin
            fp_state_d = pwdata;
        end
        if (!core_reset_n) begin
            pwr_ctrl_d = PWR_CTRL_RST;
            fp_state_d = FP_STATE_RST;
        end
        if (!simd_reset_n) begin
            simd_state_d = SIMD_STATE_RST;
        end
        if (!debug_reset_n) begin
            watch_d = WATCH_RST;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= '0;
            pwr_ctrl_q <= PWR_CTRL_RST;
            watch_q <= WATCH_RST;
            simd_state_q <= SIMD_STATE_RST;
            fp_state_q <= FP_STATE_RST;
        end else begin
            rdata_q <= rdata_d;
            pwr_ctrl_q <= pwr_ctrl_d;
            watch_q <= watch_d;
            simd_state_q <= simd_state_d;
            fp_state_q <= fp_state_d;
        end
    end

    assign prdata = rdata_q;

    // reset level inputs are taken as already synchronous to the clock
    always_comb begin
        mode_d = decode_mode(core_reset_n, simd_reset_n, debug_reset_n);
        in_rst_d = {~debug_reset_n, ~simd_reset_n, ~core_reset_n};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= MODE_COLD;
            in_rst_q <= 3'h7;
        end else begin
            mode_q <= mode_d;
            in_rst_q <= in_rst_d;
        end
    end

    assign reset_mode = mode_q;
    assign core_in_reset = in_rst_q[0];
    assign simd_in_reset = in_rst_q[1];
    assign debug_in_reset = in_rst_q[2];

    // idle conditions per gated domain
    always_comb begin
        idle_vec[GATE_CORE] = (core_empty && (icache_linefill_miss || itlb_miss)) ||
                              (core_full && (dcache_linefill_miss || store_stall_lfb_busy));
        idle_vec[GATE_SYSCTL] = !sysctl_instr_exec && !sysctl_instr_pipe &&
                                !perf_events_en && !debug_en;
        idle_vec[GATE_SIMD] = !simd_instr_engine && !simd_instr_pipe;
        // keep clocks running while a domain is in reset so it actually initializes
        hold_vec[GATE_CORE] = !core_reset_n;
        hold_vec[GATE_SYSCTL] = !core_reset_n;
        hold_vec[GATE_SIMD] = !simd_reset_n;
        off_vec = '0;
        // clock-off stops the simd clock even in reset, so release lands on one edge
        off_vec[GATE_SIMD] = simd_clock_off;
    end

    genvar g;
    generate
        for (g = 0; g < NUM_GATED; g++) begin : g_gate
            clock_gate_ctrl u_gate (
                .pclk(pclk),
                .presetn(presetn),
                .enable(gate_en),
                .latency(max_lat),
                .idle(idle_vec[g]),
                .hold_on(hold_vec[g]),
                .force_off(off_vec[g]),
                .clk_en(en_vec[g])
            );
        end
    endgenerate

    assign core_clk_en = en_vec[GATE_CORE];
    assign sysctl_clk_en = en_vec[GATE_SYSCTL];
    assign simd_clk_en = en_vec[GATE_SIMD];

    bus_ratio_port u_bus (
        .pclk(pclk),
        .presetn(presetn),
        .core_reset_n(core_reset_n),
        .bus_master_port_bus_clock_enable(bus_master_port_bus_clock_enable),
        .core_data(core_bus_data),
        .core_valid(core_bus_valid),
        .bus_data(bus_out_data),
        .bus_valid(bus_out_valid)
    );

    // ---------------- checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_bus_out_hold: assert property (
        core_reset_n && !bus_master_port_bus_clock_enable |=> $stable(bus_out_data) && $stable(bus_out_valid))
        else $error("bus output changed without clock enable");

    chk_reset_flags: assert property (
        !core_reset_n && !simd_reset_n |=> core_in_reset && simd_in_reset)
        else $error("reset flag not raised");

    chk_core_reset_clear: assert property (
        !core_reset_n |=> fp_state_q == FP_STATE_RST && pwr_ctrl_q == PWR_CTRL_RST)
        else $error("core reset did not clear core state");

    chk_simd_reset_alone: assert property (
        !simd_reset_n && core_reset_n && !wr_ok |=> simd_state_q == SIMD_STATE_RST &&
        $stable(fp_state_q))
        else $error("simd reset not isolated");

    chk_debug_reset_clear: assert property (
        !debug_reset_n |=> watch_q == WATCH_RST)
        else $error("debug reset did not clear watch state");

    chk_warm_keeps_debug: assert property (
        debug_reset_n && !core_reset_n && !simd_reset_n && !wr_ok |=> $stable(watch_q))
        else $error("warm reset disturbed debug state");

    chk_core_gate_cause: assert property (
        !core_clk_en |-> $past(gate_en) && $past(idle_vec[GATE_CORE]) && $past(core_reset_n))
        else $error("core clock stopped without cause");

    chk_sysctl_gate_cause: assert property (
        !sysctl_clk_en |-> $past(gate_en) && $past(idle_vec[GATE_SYSCTL]))
        else $error("system control clock stopped without cause");

    chk_simd_gate_cause: assert property (
        !simd_clk_en |-> $past(simd_clock_off) ||
        ($past(gate_en) && $past(idle_vec[GATE_SIMD]) && $past(simd_reset_n)))
        else $error("simd clock stopped without cause");

    chk_resume_prompt: assert property (
        !idle_vec[GATE_CORE] |=> core_clk_en)
        else $error("core clock not resumed in time");

    chk_gate_off_default: assert property (
        !core_reset_n ##1 core_reset_n && !wr_ok |=> !gate_en)
        else $error("gating enabled after reset");

    cov_cold_reset: cover property (mode_q == MODE_COLD ##1 mode_q == MODE_RUN);
    cov_warm_reset: cover property (mode_q == MODE_WARM);
    cov_simd_por: cover property (mode_q == MODE_SIMD_POR && !simd_clk_en);
    cov_core_gated: cover property (!core_clk_en ##1 core_clk_en);

endmodule : core_clock_reset_gating

// ==== rtl/core_clk_rst_pkg.sv ====
// shared constants, types and decode functions for the core clock and reset block
package core_clk_rst_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int LAT_W = 4;

    // register byte offsets
    localparam logic [ADDR_W-1:0] PWR_CTRL_OFF = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h04;
    localparam logic [ADDR_W-1:0] WATCH_OFF = 8'h08;
    localparam logic [ADDR_W-1:0] SIMD_STATE_OFF = 8'h0c;
    localparam logic [ADDR_W-1:0] FP_STATE_OFF = 8'h10;

    // power control fields
    localparam int GATE_EN_BIT = 0;
    localparam int LAT_LSB = 4;
    localparam logic [DATA_W-1:0] PWR_CTRL_MASK = 32'h0000_00f1;

    // status fields
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_CLK_LSB = 4;
    localparam int STAT_RST_LSB = 8;

    // reset values
    localparam logic [DATA_W-1:0] PWR_CTRL_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] WATCH_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] SIMD_STATE_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] FP_STATE_RST = 32'h0000_0000;

    // gated clock domains
    localparam int NUM_GATED = 3;
    localparam int GATE_CORE = 0;
    localparam int GATE_SYSCTL = 1;
    localparam int GATE_SIMD = 2;

    typedef enum logic [2:0] {
        MODE_COLD,
        MODE_WARM,
        MODE_SIMD_POR,
        MODE_DEBUG,
        MODE_RUN,
        MODE_OTHER
    } reset_mode_t;

    function automatic reset_mode_t decode_mode(input logic core_n, input logic simd_n,
                                                input logic dbg_n);
        reset_mode_t m;
        case ({core_n, simd_n, dbg_n})
            3'b000: m = MODE_COLD;
            3'b001: m = MODE_WARM;
            3'b101: m = MODE_SIMD_POR;
            3'b110: m = MODE_DEBUG;
            3'b111: m = MODE_RUN;
            default: m = MODE_OTHER;
        endcase
        return m;
    endfunction : decode_mode

    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        return (addr == PWR_CTRL_OFF) || (addr == STATUS_OFF) || (addr == WATCH_OFF) ||
               (addr == SIMD_STATE_OFF) || (addr == FP_STATE_OFF);
    endfunction : is_mapped

endpackage : core_clk_rst_pkg

// ==== rtl/clock_gate_ctrl.sv ====
// idle-driven clock enable for one gated domain
`timescale 1ns/1ps
module clock_gate_ctrl
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic enable,
    input wire logic [core_clk_rst_pkg::LAT_W-1:0] latency,
    input wire logic idle,
    input wire logic hold_on,
    input wire logic force_off,
    // result
    output logic clk_en
);
    import core_clk_rst_pkg::*;
    logic [LAT_W-1:0] cnt_q, cnt_d;
    logic clk_en_q, clk_en_d;
    logic gated;

    always_comb begin
        // idle must persist past the latency window before the clock stops
        gated = enable && idle && !hold_on && (cnt_q >= latency);
        if (!enable || !idle || hold_on) begin
            cnt_d = '0;
        end else if (cnt_q < latency) begin
            cnt_d = cnt_q + 1'b1;
        end else begin
            cnt_d = cnt_q;
        end
        // resume is one cycle after work arrives, inside any latency setting
        clk_en_d = !(force_off || gated);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            clk_en_q <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            clk_en_q <= clk_en_d;
        end
    end

    assign clk_en = clk_en_q;

endmodule : clock_gate_ctrl

// ==== rtl/bus_ratio_port.sv ====
// master port outputs updated only on bus clock-enable edges, or cleared on any edge while core reset is low
`timescale 1ns/1ps
module bus_ratio_port
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic core_reset_n,
    // ratio strobe
    input wire logic bus_master_port_bus_clock_enable,
    // core side
    input wire logic [core_clk_rst_pkg::DATA_W-1:0] core_data,
    input wire logic core_valid,
    // bus side
    output logic [core_clk_rst_pkg::DATA_W-1:0] bus_data,
    output logic bus_valid
);
    import core_clk_rst_pkg::*;
    logic [DATA_W-1:0] data_q, data_d;
    logic valid_q, valid_d;

    always_comb begin
        data_d = data_q;
        valid_d = valid_q;
        if (!core_reset_n) begin
            data_d = '0;
            valid_d = 1'b0;
        end else if (bus_master_port_bus_clock_enable) begin
            data_d = core_data;
            valid_d = core_valid;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q <= '0;
            valid_q <= 1'b0;
        end else begin
            data_q <= data_d;
            valid_q <= valid_d;
        end
    end

    assign bus_data = data_q;
    assign bus_valid = valid_q;

endmodule : bus_ratio_port

// ==== verification/reset_ctrl_model.sv ====
// behavioural reset and power controller on the far side of the core
`timescale 1ns/1ps
module reset_ctrl_model (
    // clock
    input wire logic pclk,
    // command: 0 cold, 1 warm, 2 simd, 3 debug
    input wire logic go,
    input wire logic [1:0] kind,
    // reset controls
    output logic core_reset_n,
    output logic simd_reset_n,
    output logic debug_reset_n,
    output logic simd_clock_off,
    output logic busy
);
    task automatic run(input logic [1:0] k);
        logic [2:0] lv;
        case (k)
            2'd0: lv = 3'b000;
            2'd1: lv = 3'b001;
            2'd2: lv = 3'b101;
            default: lv = 3'b110;
        endcase
        if (k == 2'd0) begin
            // falling edge need not line up with the clock
            #7;
            {core_reset_n, simd_reset_n, debug_reset_n} = lv;
        end else begin
            {core_reset_n, simd_reset_n, debug_reset_n} <= lv;
        end
        // 15 rather than nine for margin
        repeat (15) @(posedge pclk);
        if (k == 2'd0 || k == 2'd2) begin
            simd_clock_off <= 1'b1;
            repeat (10) @(posedge pclk);
        end
        {core_reset_n, simd_reset_n, debug_reset_n} <= 3'b111;
        if (simd_clock_off) begin
            repeat (10) @(posedge pclk);
            simd_clock_off <= 1'b0;
        end
    endtask : run

    initial begin
        {core_reset_n, simd_reset_n, debug_reset_n} = 3'b111;
        simd_clock_off = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge pclk);
            if (go === 1'b1) begin
                busy <= 1'b1;
                run(kind);
                busy <= 1'b0;
            end
        end
    end
endmodule : reset_ctrl_model

// ==== verification/core_clock_reset_gating_tb_top.sv ====
// self-checking bench for the core clock, reset and gating block
`timescale 1ns/1ps
module core_clock_reset_gating_tb_top;
    import core_clk_rst_pkg::*;
    // sysctl and simd busy, core not stalled
    localparam logic [11:0] BUSY = 12'h440;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, core_bus_data, bus_out_data;
    logic core_bus_valid, bus_out_valid, bus_master_port_bus_clock_enable;
    logic core_reset_n, simd_reset_n, debug_reset_n, simd_clock_off, go, busy;
    logic [1:0] kind;
    logic [11:0] act;
    logic [2:0] clk_en, in_rst, reset_mode;
    int n_errors, n_compared;

    core_clock_reset_gating core_clock_reset_gating_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .core_reset_n, .simd_reset_n, .debug_reset_n, .simd_clock_off,
        .bus_master_port_bus_clock_enable, .core_bus_data, .core_bus_valid, .bus_out_data,
        .bus_out_valid, .core_empty(act[0]), .core_full(act[1]),
        .icache_linefill_miss(act[2]), .itlb_miss(act[3]), .dcache_linefill_miss(act[4]),
        .store_stall_lfb_busy(act[5]), .sysctl_instr_exec(act[6]),
        .sysctl_instr_pipe(act[7]), .perf_events_en(act[8]), .debug_en(act[9]),
        .simd_instr_engine(act[10]), .simd_instr_pipe(act[11]), .core_clk_en(clk_en[0]),
        .sysctl_clk_en(clk_en[1]), .simd_clk_en(clk_en[2]), .core_in_reset(in_rst[2]),
        .simd_in_reset(in_rst[1]), .debug_in_reset(in_rst[0]), .reset_mode
    );

    reset_ctrl_model reset_ctrl_model_inst (
        .pclk, .go, .kind, .core_reset_n, .simd_reset_n, .debug_reset_n, .simd_clock_off,
        .busy
    );

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rdchk(input string s, input logic [7:0] a, input logic [31:0] x,
                         input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(s, x, r);
        check({s, " err"}, {31'h0, xe}, {31'h0, e});
    endtask : rdchk

    task automatic t_regs;
        rdchk("pwr rst", PWR_CTRL_OFF, PWR_CTRL_RST, 1'b0);
        rdchk("watch rst", WATCH_OFF, WATCH_RST, 1'b0);
        rdchk("fp rst", FP_STATE_OFF, FP_STATE_RST, 1'b0);
        wr(PWR_CTRL_OFF, 32'hffff_ffff);
        rdchk("pwr fields", PWR_CTRL_OFF, PWR_CTRL_MASK, 1'b0);
        wr(STATUS_OFF, 32'hffff_ffff);
        rdchk("status", STATUS_OFF, 32'h0000_0074, 1'b0);
        rdchk("unmapped", 8'h14, 32'h0, 1'b1);
        wr(PWR_CTRL_OFF, 32'h0);
        $display("test regs done");
    endtask : t_regs

    task automatic t_ratio;
        logic [31:0] xd;
        logic xv;
        xd = '0;
        xv = 1'b0;
        // 3:1 ratio; outputs must hold between enabled edges
        for (int i = 0; i < 10; i++) begin
            @(posedge pclk);
            // the port loads what it samples at this very edge
            if (bus_master_port_bus_clock_enable === 1'b1) begin
                xd = core_bus_data;
                xv = core_bus_valid;
            end
            core_bus_data <= 32'h5a00_0000 + 32'(i);
            core_bus_valid <= i[0];
            bus_master_port_bus_clock_enable <= (i % 3 == 0);
            #1;
            check("bus data", xd, bus_out_data);
            check("bus valid", {31'h0, xv}, {31'h0, bus_out_valid});
        end
        $display("test ratio done");
    endtask : t_ratio

    task automatic wait_en(input int d, input logic lvl, output int n);
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (clk_en[d] !== lvl && n < 40);
    endtask : wait_en

    task automatic gate(input string s, input logic [11:0] a, input int d, input int lat);
        int n;
        @(posedge pclk);
        act <= a;
        wait_en(d, 1'b0, n);
        check({s, " off"}, 32'(lat + 1), 32'(n));
        @(posedge pclk);
        act <= BUSY;
        wait_en(d, 1'b1, n);
        check({s, " on"}, 32'd1, 32'(n));
    endtask : gate

    task automatic hold(input string s, input logic [11:0] a, input int d);
        @(posedge pclk);
        act <= a;
        repeat (20) @(posedge pclk);
        #1;
        check(s, 32'h1, {31'h0, clk_en[d]});
        @(posedge pclk);
        act <= BUSY;
    endtask : hold

    task automatic t_gate;
        logic [11:0] stall [4] = '{12'h005, 12'h009, 12'h012, 12'h022};
        for (int d = 0; d < 3; d++) hold("gating off", 12'h005, d);
        wr(PWR_CTRL_OFF, 32'h0000_0021);
        for (int i = 0; i < 4; i++) gate("core stall", stall[i] | BUSY, 0, 2);
        hold("empty data miss", 12'h011 | BUSY, 0);
        gate("sysctl idle", 12'h400, 1, 2);
        for (int b = 6; b < 10; b++) hold("sysctl busy", 12'h400 | (12'h001 << b), 1);
        gate("simd idle", 12'h040, 2, 2);
        hold("simd pipe", 12'h840, 2);
        wr(PWR_CTRL_OFF, 32'h0000_0001);
        gate("zero latency", 12'h040, 2, 0);
        wr(PWR_CTRL_OFF, 32'h0);
        $display("test gating done");
    endtask : t_gate

    task automatic t_reset(input string s, input logic [1:0] k, input logic [2:0] lv);
        wr(PWR_CTRL_OFF, 32'hffff_ffff);
        wr(WATCH_OFF, 32'h0000_00aa);
        wr(SIMD_STATE_OFF, 32'h0000_00bb);
        wr(FP_STATE_OFF, 32'h0000_00cc);
        @(posedge pclk);
        go <= 1'b1;
        kind <= k;
        @(posedge pclk);
        go <= 1'b0;
        repeat (5) @(posedge pclk);
        #1;
        check({s, " mode"}, 32'(k), {29'h0, reset_mode});
        check({s, " flags"}, {29'h0, ~lv}, {29'h0, in_rst});
        repeat (15) @(posedge pclk);
        #1;
        // only cold and simd sequences raise clock-off; warm keeps the simd clock running
        check({s, " clk off"}, (k == 2'd0 || k == 2'd2) ? 32'h0 : 32'h1,
              {31'h0, clk_en[2]});
        for (int i = 0; i < 100 && busy === 1'b1; i++) @(posedge pclk);
        repeat (3) @(posedge pclk);
        rdchk({s, " pwr"}, PWR_CTRL_OFF, lv[2] ? PWR_CTRL_MASK : 32'h0, 1'b0);
        rdchk({s, " watch"}, WATCH_OFF, lv[0] ? 32'haa : 32'h0, 1'b0);
        rdchk({s, " simd"}, SIMD_STATE_OFF, lv[1] ? 32'hbb : 32'h0, 1'b0);
        rdchk({s, " fp"}, FP_STATE_OFF, lv[2] ? 32'hcc : 32'h0, 1'b0);
        rdchk({s, " status"}, STATUS_OFF, 32'h0000_0074, 1'b0);
        $display("test %s done", s);
    endtask : t_reset

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, go} = 4'h0;
        paddr = '0;
        pwdata = '0;
        kind = 2'd0;
        act = BUSY;
        core_bus_data = '0;
        core_bus_valid = 1'b0;
        bus_master_port_bus_clock_enable = 1'b0;
        n_errors = 0;
        n_compared = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_ratio();
        t_gate();
        t_reset("cold", 2'd0, 3'b000);
        t_reset("warm", 2'd1, 3'b001);
        t_reset("simd", 2'd2, 3'b101);
        t_reset("debug", 2'd3, 3'b110);
        give_verdict();
    end

    // whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        give_verdict();
    end
endmodule : core_clock_reset_gating_tb_top
